// ==== hw/pms_pkg.sv ====
// Purpose: Shared constants and state type of the programmable Mealy sequencer
// Assumes: APB register slave, single 10 MHz clock pclk, async active-low presetn
// Notes: Operation summary below, one line per tag
//
// Operation
// (RULE1) Reset places every state and output register bit at one.
// (RULE2) Each of 48 terms sees all 16 inputs and 6 state bits.
// (RULE3) Each variable links true, complement or don't care; both links kill the term.
// (RULE4) Terms match present state using true, false or don't care per state bit.
// (RULE5) OR array lets any set of terms drive J or K of any bit.
// (RULE6) Complement array inverts a term group and feeds it back as a variable.
// (RULE7) All register bits are rising-edge J-K flip-flops; J and K together toggle.
// (RULE8) With at most one of J or K active, behaviour equals set-reset flops.
// (RULE9) Option selects shared pin as preset of all registers or output enable.
// (RULE10) Unprogrammed: every term inactive, shared pin option is preset.
// (RULE11) Diagnostic features load registers directly and show buried state outside.
// (RULE12) The configurer sets unused complement, input and state links to don't care.
// (RULE13) Unused terms stay inactive, or all don't care for speed.
// (RULE14) Preset high forces ones, inhibits clocking; resume after one skipped edge.
// (RULE15) State-observe diagnostic shows state bits 0-5 on outputs 0-5.
// (RULE16) State-load diagnostic loads outputs 0-5 pins into state bits on clock edge.
// (RULE17) Output-load diagnostic loads all eight pins into output register on clock edge.
// (RULE18) Outputs show output register; buffers off when OE option and pin high.
// (RULE19) A bit with J and K both inactive holds its value.
// (RULE20) Array connections are static parameters so one logic fits any design.
////////////////////////////////////////////////////////////////////////////////
package pms_pkg;

    localparam int PMS_NUM_IN = 16;
    localparam int PMS_NUM_ST = 6;
    localparam int PMS_NUM_OUT = 8;
    localparam int PMS_NUM_TERM = 48;
    localparam int PMS_NUM_VAR = PMS_NUM_IN + PMS_NUM_ST + 1;
    localparam int PMS_NUM_REG = PMS_NUM_ST + PMS_NUM_OUT;
    localparam int PMS_COMP_VAR = PMS_NUM_VAR - 1;
    localparam int PMS_ADDR_W = 8;

    // Register byte offsets
    localparam logic [7:0] PMS_CTRL_OFS = 8'h00;
    localparam logic [7:0] PMS_STAT_OFS = 8'h04;
    localparam logic [7:0] PMS_INPUT_OFS = 8'h08;

    // Control field positions
    localparam int PMS_CTRL_HOLD_BIT = 0;
    localparam int PMS_CTRL_SPRE_BIT = 1;

    // Status field positions
    localparam int PMS_STAT_STATE_LSB = 0;
    localparam int PMS_STAT_OUT_LSB = 8;
    localparam int PMS_STAT_MODE_BIT = 16;
    localparam int PMS_STAT_WAIT_BIT = 17;
    localparam int PMS_STAT_PRE_BIT = 18;

    // Values after reset
    localparam logic [5:0] PMS_STATE_RST = 6'h3f;
    localparam logic [7:0] PMS_OUT_RST = 8'hff;
    localparam logic [1:0] PMS_CTRL_RST = 2'h0;

    typedef struct packed {
        logic [15:0] din_s1;
        logic [15:0] din_s2;
        logic [7:0] fin_s1;
        logic [7:0] fin_s2;
        logic pin_s1;
        logic pin_s2;
        logic [2:0] diag_s1;
        logic [2:0] diag_s2;
        logic [5:0] state_reg;
        logic [7:0] out_reg;
        logic resume_wait;
        logic [1:0] ctrl;
        logic [7:0] fout;
        logic [7:0] fout_oe;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } pms_state_s;

endpackage

// ==== hw/pms_and_array.sv ====
// Purpose: Programmable AND array producing transition terms
// Assumes: Link masks are static parameters
// Notes: Purely combinational
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module pms_and_array #(
    parameter int NV = 23,
    parameter int NT = 48,
    parameter logic [NT-1:0][NV-1:0] TRUE_LINK = '1,
    parameter logic [NT-1:0][NV-1:0] COMP_LINK = '1
) (
    // Variables
    input wire logic [NV-1:0] vars,
    // Terms
    output logic [NT-1:0] terms
);

    genvar t;
    generate
        for (t = 0; t < NT; t++) begin : g_term
            // Both links intact gives x and not x, so the term is dead
            assign terms[t] = &((~TRUE_LINK[t] | vars) & (~COMP_LINK[t] | ~vars)); // RULE2 RULE3 RULE4
        end
    endgenerate

endmodule

// ==== hw/pms_top.sv ====
// Purpose: Programmable Mealy sequencer core with APB status and control
// Assumes: Pins are asynchronous to pclk and pass two flip-flops
// Notes: High-voltage diagnostic levels arrive as separate detect inputs
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module pms_top
    import pms_pkg::*;
#(
    parameter logic [PMS_NUM_TERM-1:0][PMS_NUM_VAR-1:0] TERM_TRUE = '1, // RULE10
    parameter logic [PMS_NUM_TERM-1:0][PMS_NUM_VAR-1:0] TERM_COMP = '1,
    parameter logic [PMS_NUM_TERM-1:0] COMP_GROUP = '0,
    parameter logic [PMS_NUM_REG-1:0][PMS_NUM_TERM-1:0] J_SELECT = '0,
    parameter logic [PMS_NUM_REG-1:0][PMS_NUM_TERM-1:0] K_SELECT = '0,
    parameter logic PRESET_OPTION = 1'b1 // RULE10
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [PMS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sequencer pins
    input wire logic [PMS_NUM_IN-1:0] dedicated_inputs,
    input wire logic preset_or_outen_pin,
    input wire logic output_load_diag_input,
    input wire logic state_load_diag_input,
    input wire logic state_observe_diag_input,
    // Two-way output pins
    input wire logic [PMS_NUM_OUT-1:0] registered_outputs_i,
    output logic [PMS_NUM_OUT-1:0] registered_outputs_o,
    output logic [PMS_NUM_OUT-1:0] registered_outputs_oe
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    pms_state_s cur;
    pms_state_s next_cur;
    logic [PMS_NUM_VAR-1:0] vars_pass1;
    logic [PMS_NUM_VAR-1:0] vars_pass2;
    logic [PMS_NUM_TERM-1:0] terms_pass1;
    logic [PMS_NUM_TERM-1:0] terms;
    logic comp_term;
    logic [PMS_NUM_REG-1:0] reg_now;
    logic [PMS_NUM_REG-1:0] reg_jk;

    // First pass ignores the complement column so the group cannot loop
    localparam logic [PMS_NUM_VAR-1:0] NO_COMP_COL = ~({{(PMS_NUM_VAR-1){1'b0}}, 1'b1} << PMS_COMP_VAR);

    function automatic logic [PMS_NUM_TERM-1:0][PMS_NUM_VAR-1:0] strip_comp(
        input logic [PMS_NUM_TERM-1:0][PMS_NUM_VAR-1:0] links
    );
        logic [PMS_NUM_TERM-1:0][PMS_NUM_VAR-1:0] res;
        res = links;
        for (int i = 0; i < PMS_NUM_TERM; i++) begin
            res[i] = links[i] & NO_COMP_COL;
        end
        return res;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Term arrays
    assign vars_pass1 = {1'b0, cur.state_reg, cur.din_s2}; // RULE2
    assign vars_pass2 = {comp_term, cur.state_reg, cur.din_s2}; // RULE2 RULE4

    // Static link patterns realise any programmed design
    pms_and_array #(
        .NV(PMS_NUM_VAR),
        .NT(PMS_NUM_TERM),
        .TRUE_LINK(strip_comp(TERM_TRUE)),
        .COMP_LINK(strip_comp(TERM_COMP))
    ) u_pass1 (
        .vars(vars_pass1),
        .terms(terms_pass1)
    ); // RULE20

    assign comp_term = ~|(terms_pass1 & COMP_GROUP); // RULE6

    pms_and_array #(
        .NV(PMS_NUM_VAR),
        .NT(PMS_NUM_TERM),
        .TRUE_LINK(TERM_TRUE),
        .COMP_LINK(TERM_COMP)
    ) u_pass2 (
        .vars(vars_pass2),
        .terms(terms)
    ); // RULE6 RULE10 RULE20

    ////////////////////////////////////////////////////////////////////////////
    // OR array and J-K next values, one per register bit
    assign reg_now = {cur.out_reg, cur.state_reg};

    genvar b;
    generate
        for (b = 0; b < PMS_NUM_REG; b++) begin : g_jk
            logic j_in;
            logic k_in;
            assign j_in = |(terms & J_SELECT[b]); // RULE5
            assign k_in = |(terms & K_SELECT[b]); // RULE5
            // Toggle, set, reset or hold; lone J or K acts as set-reset
            assign reg_jk[b] = (j_in & ~reg_now[b]) | (~k_in & reg_now[b]); // RULE7 RULE8 RULE19
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        logic preset_act;
        logic oe_pin_high;
        logic clk_ok;
        logic out_load;
        logic st_load;
        logic observe;
        logic acc_done;
        logic [31:0] rd;
        logic err;
        preset_act = 1'b0;
        oe_pin_high = 1'b0;
        clk_ok = 1'b0;
        out_load = 1'b0;
        st_load = 1'b0;
        observe = 1'b0;
        acc_done = 1'b0;
        rd = 32'h0000_0000;
        err = 1'b0;
        next_cur = cur;

        // Two-flop synchronisers on every pin
        next_cur.din_s1 = dedicated_inputs;
        next_cur.din_s2 = cur.din_s1;
        next_cur.fin_s1 = registered_outputs_i;
        next_cur.fin_s2 = cur.fin_s1;
        next_cur.pin_s1 = preset_or_outen_pin;
        next_cur.pin_s2 = cur.pin_s1;
        next_cur.diag_s1 = {state_observe_diag_input, state_load_diag_input, output_load_diag_input};
        next_cur.diag_s2 = cur.diag_s1;

        out_load = cur.diag_s2[0];
        st_load = cur.diag_s2[1];
        observe = cur.diag_s2[2];

        // Shared pin meaning chosen by option
        preset_act = (PRESET_OPTION & cur.pin_s2) | cur.ctrl[PMS_CTRL_SPRE_BIT]; // RULE9
        oe_pin_high = ~PRESET_OPTION & cur.pin_s2; // RULE9 RULE18

        // Preset skips the first edge after release, like the falling-edge wait
        next_cur.resume_wait = preset_act | (cur.resume_wait & cur.ctrl[PMS_CTRL_HOLD_BIT]); // RULE14
        clk_ok = ~preset_act & ~cur.resume_wait & ~cur.ctrl[PMS_CTRL_HOLD_BIT]; // RULE14

        if (preset_act) begin
            next_cur.state_reg = PMS_STATE_RST; // RULE14
            next_cur.out_reg = PMS_OUT_RST; // RULE14
        end else if (clk_ok) begin
            if (out_load) begin
                next_cur.out_reg = cur.fin_s2; // RULE17
            end else if (st_load) begin
                next_cur.state_reg = cur.fin_s2[5:0]; // RULE16
            end else begin
                next_cur.state_reg = reg_jk[5:0]; // RULE7
                next_cur.out_reg = reg_jk[13:6]; // RULE7
            end
        end

        // Output pins, registered from the next register values
        next_cur.fout = next_cur.out_reg; // RULE18
        if (observe) begin
            next_cur.fout[5:0] = next_cur.state_reg; // RULE11 RULE15
        end
        if (out_load | oe_pin_high) begin
            next_cur.fout_oe = 8'h00; // RULE17 RULE18
        end else if (st_load) begin
            next_cur.fout_oe = 8'hc0; // RULE16
        end else begin
            next_cur.fout_oe = 8'hff;
        end

        // APB slave: one wait state, then answer
        acc_done = psel & penable & cur.pready;
        next_cur.pready = psel & penable & ~cur.pready;
        unique case (paddr)
            PMS_CTRL_OFS: begin
                rd = {30'h0000_0000, cur.ctrl};
            end
            PMS_STAT_OFS: begin
                rd[PMS_STAT_STATE_LSB +: PMS_NUM_ST] = cur.state_reg; // RULE11
                rd[PMS_STAT_OUT_LSB +: PMS_NUM_OUT] = cur.out_reg;
                rd[PMS_STAT_MODE_BIT] = PRESET_OPTION;
                rd[PMS_STAT_WAIT_BIT] = cur.resume_wait;
                rd[PMS_STAT_PRE_BIT] = preset_act;
            end
            PMS_INPUT_OFS: begin
                rd = {16'h0000, cur.din_s2};
            end
            default: begin
                err = 1'b1;
            end
        endcase
        if (next_cur.pready) begin
            next_cur.prdata = pwrite ? 32'h0000_0000 : rd;
            next_cur.pslverr = err;
        end else begin
            next_cur.prdata = 32'h0000_0000;
            next_cur.pslverr = 1'b0;
        end
        if (acc_done & pwrite & (paddr == PMS_CTRL_OFS)) begin
            next_cur.ctrl = pwdata[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '0;
            cur.state_reg <= PMS_STATE_RST; // RULE1
            cur.out_reg <= PMS_OUT_RST; // RULE1
            cur.fout <= PMS_OUT_RST; // RULE1
            cur.fout_oe <= 8'h00;
            cur.ctrl <= PMS_CTRL_RST;
        end else begin
            cur <= next_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs straight from flops
    assign prdata = cur.prdata;
    assign pready = cur.pready;
    assign pslverr = cur.pslverr;
    assign registered_outputs_o = cur.fout;
    assign registered_outputs_oe = cur.fout_oe;

endmodule

// ==== tb/pms_top_properties.sv ====
// Purpose: Port-level checks of the sequencer core
// Assumes: Preset option selected, one clock domain
// Notes: Pin and diag inputs pass two sync stages, hence the four-cycle waits
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module pms_checker (
    // Clock, reset and bus
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Pins
    input wire logic preset_or_outen_pin,
    input wire logic output_load_diag_input,
    input wire logic state_load_diag_input,
    input wire logic state_observe_diag_input,
    input wire logic [7:0] registered_outputs_o,
    input wire logic [7:0] registered_outputs_oe
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////
    ready_wait_a: assert property (psel && penable && !$past(penable) |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    ready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    err_map_a: assert property (pready |-> pslverr == !(paddr inside {8'h00, 8'h04, 8'h08}))
        else $error("pslverr does not match address map");
    idle_zero_a: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside answer");
    reset_ones_a: assert property ($rose(presetn) |-> registered_outputs_o == 8'hff)
        else $error("outputs not all ones after reset");
    preset_ones_a: assert property (preset_or_outen_pin [*4] |-> registered_outputs_o == 8'hff)
        else $error("outputs not high under preset");
    observe_state_a: assert property (state_observe_diag_input [*4] ##0 (pready && paddr == 8'h04)
        |-> prdata[5:0] == registered_outputs_o[5:0])
        else $error("observed pins differ from state");
    sload_oe_a: assert property (state_load_diag_input [*4] |-> registered_outputs_oe[5:0] == 6'h0)
        else $error("low pins still driven in state load");
    oload_oe_a: assert property (output_load_diag_input [*4] |-> registered_outputs_oe == 8'h0)
        else $error("pins still driven in output load");
    oe_norm_a: assert property (!(output_load_diag_input || state_load_diag_input) [*4]
        |-> registered_outputs_oe == 8'hff)
        else $error("pins not driven in normal mode");
endmodule

// ==== tb/pms_partner.sv ====
// Purpose: Surrounding logic on the eight output pins
// Assumes: No pull resistors on the pins
// Notes: A floating pin shows the inverse of its last level, so it toggles on every clock
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module pms_partner (
    // Clock
    input wire logic pclk,
    // Device side
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    // Bench control
    input wire logic drive_en,
    input wire logic [7:0] drive_val,
    // Resolved pins
    output logic [7:0] pin_i
);
    logic [7:0] last = 8'h00;
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            pin_i[k] = pin_oe[k] ? pin_o[k] : (drive_en ? drive_val[k] : ~last[k]);
        end
    end
    always @(posedge pclk) begin
        last <= pin_i;
    end
endmodule

// ==== tb/pms_top_test.sv ====
// Purpose: Scenario bench of the sequencer core
// Assumes: Six-term program: set, reset, follow, complement else branch
// Notes: State and output registers are read through the status register
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
module pms_top_test
    import pms_pkg::*;
;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, preset_or_outen_pin = 0;
    logic output_load_diag_input = 0, state_load_diag_input = 0, state_observe_diag_input = 0, drv = 0;
    logic [7:0] paddr = 0, drv_val = 0, registered_outputs_i, registered_outputs_o, registered_outputs_oe;
    logic [31:0] pwdata = 0, prdata, rdat;
    logic [15:0] dedicated_inputs = 0;
    logic rerr;
    int fails = 0, num_checks = 0;
    // Terms: 0 in0 set st0, 1 in1 reset st0, 2/3 out0 follows st0, 4/5 out1 from else of term 0
    function automatic logic [47:0][22:0] links(input bit comp);
        logic [47:0][22:0] m;
        m = '1;
        for (int t = 0; t < 6; t++) m[t] = '0;
        if (!comp) begin
            m[0][0] = 1;
            m[1][1] = 1;
            m[2][16] = 1;
            m[4][22] = 1;
        end else begin
            m[3][16] = 1;
            m[5][22] = 1;
        end
        return m;
    endfunction
    function automatic logic [13:0][47:0] sel(input int k);
        logic [13:0][47:0] m;
        m = '0;
        m[0][k] = 1;
        m[6][2 + k] = 1;
        m[7][4 + k] = 1;
        // Dead terms 6 and 7 on out7: both live would toggle it
        m[13][6 + k] = 1;
        return m;
    endfunction
    always #50 pclk = ~pclk;
    pms_top #(.TERM_TRUE(links(0)), .TERM_COMP(links(1)), .COMP_GROUP(48'h1), .J_SELECT(sel(0)),
        .K_SELECT(sel(1)), .PRESET_OPTION(1'b1)) dut_u (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .dedicated_inputs, .preset_or_outen_pin,
        .output_load_diag_input, .state_load_diag_input, .state_observe_diag_input,
        .registered_outputs_i, .registered_outputs_o, .registered_outputs_oe);
    pms_partner far_u (.pclk(pclk), .pin_o(registered_outputs_o), .pin_oe(registered_outputs_oe),
        .drive_en(drv), .drive_val(drv_val), .pin_i(registered_outputs_i));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic conclude;
        if (fails == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        tick(3);
        check(registered_outputs_o, 8'hff);
        apb(0, PMS_STAT_OFS, 0);
        check(rdat[18:0], 19'h1ff3f);
    endtask
    task automatic t_setrst;
        dedicated_inputs <= 16'h2;
        tick(6);
        apb(0, PMS_STAT_OFS, 0);
        check(rdat[15:0], 16'hfe3e);
        check(registered_outputs_o, 8'hfe);
    endtask
    task automatic t_toggle;
        logic [31:0] r1;
        dedicated_inputs <= 16'h3;
        tick(6);
        apb(0, PMS_STAT_OFS, 0);
        r1 = rdat;
        // Odd gap between samples, else a toggling bit reads the same
        tick(1);
        apb(0, PMS_STAT_OFS, 0);
        check(r1[0] ^ rdat[0], 1'b1);
        check(rdat[8] ^ rdat[0], 1'b1);
        check(rdat[9], 1'b0);
    endtask
    task automatic t_hold;
        logic [31:0] r1;
        apb(1, PMS_CTRL_OFS, 32'h1);
        apb(0, PMS_CTRL_OFS, 0);
        check(rdat[1:0], 2'h1);
        apb(0, PMS_STAT_OFS, 0);
        r1 = rdat;
        apb(0, PMS_STAT_OFS, 0);
        check(rdat[15:0], r1[15:0]);
        apb(1, PMS_CTRL_OFS, 32'h0);
        dedicated_inputs <= 16'h0;
    endtask
    task automatic t_diag;
        drv_val <= 8'hd5;
        drv <= 1;
        state_load_diag_input <= 1;
        tick(6);
        check(registered_outputs_oe, 8'hc0);
        state_load_diag_input <= 0;
        drv <= 0;
        tick(6);
        apb(0, PMS_STAT_OFS, 0);
        check(rdat[15:0], 16'hff15);
        state_observe_diag_input <= 1;
        tick(5);
        apb(0, PMS_STAT_OFS, 0);
        check(registered_outputs_o[5:0], 6'h15);
        state_observe_diag_input <= 0;
        drv_val <= 8'h5a;
        drv <= 1;
        output_load_diag_input <= 1;
        tick(6);
        check(registered_outputs_oe, 8'h00);
        output_load_diag_input <= 0;
        drv <= 0;
        tick(6);
        apb(0, PMS_STAT_OFS, 0);
        check(rdat[15:0], 16'h5b15);
    endtask
    task automatic t_preset;
        preset_or_outen_pin <= 1;
        tick(5);
        check(registered_outputs_o, 8'hff);
        apb(0, PMS_STAT_OFS, 0);
        check({rdat[18], rdat[16:0]}, 18'h3ff3f);
        preset_or_outen_pin <= 0;
        apb(0, 8'h10, 0);
        check({rerr, rdat}, 33'h100000000);
        dedicated_inputs <= 16'h2;
        tick(6);
        apb(1, PMS_CTRL_OFS, 32'h2);
        apb(0, PMS_STAT_OFS, 0);
        check({rdat[18:17], rdat[15:0]}, 18'h3ff3f);
        apb(1, PMS_CTRL_OFS, 32'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        tick(2);
        presetn <= 1;
        t_reset();
        t_setrst();
        t_toggle();
        t_hold();
        t_diag();
        t_preset();
        conclude();
    end
    initial begin
        tick(2000);
        fails++;
        conclude();
    end
endmodule
bind pms_top pms_checker chk_u (.pclk, .presetn, .psel, .penable, .paddr, .prdata, .pready, .pslverr,
    .preset_or_outen_pin, .output_load_diag_input, .state_load_diag_input, .state_observe_diag_input,
    .registered_outputs_o, .registered_outputs_oe);
